// >>> i2c_pkg.sv
package i2c_pkg;
  // register byte addresses
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] data_addr = 8'h04;
  localparam logic [7:0] status_addr = 8'h08;
  localparam logic [7:0] div_addr = 8'h0c;
  // control register fields
  localparam int ctrl_scl_bit = 0;
  localparam int ctrl_sda_bit = 1;
  localparam int ctrl_oe_bit = 2;
  localparam int ctrl_rx_bit = 3;
  localparam int ctrl_ack_bit = 4;
  localparam int ctrl_stop_bit = 5;
  localparam logic [5:0] ctrl_reset = 6'h07;
  // status register fields
  localparam int stat_busy_bit = 0;
  localparam int stat_end_bit = 1;
  localparam int stat_ackerr_bit = 2;
  // clock divider reset value, quarter-bit period in aclk cycles minus one
  localparam logic [15:0] div_reset = 16'h0019;
  localparam int frame_bits = 8;
  // bus responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0] {st_idle, st_low, st_high, st_stop} phase_t;
endpackage : i2c_pkg

// >>> i2c_bit_engine.sv
`timescale 1ns/1ps
module i2c_bit_engine #(
  parameter int bits = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic stop_req,
  input wire logic rx_mode,
  input wire logic ack_en,
  input wire logic [bits-1:0] tx_byte,
  input wire logic sda_in,
  // results
  output logic busy,
  output logic done,
  output logic [bits-1:0] rx_byte,
  output logic ack_seen,
  output logic scl_low,
  output logic sda_low
);
  i2c_pkg::phase_t ph_q;
  logic [1:0] qtr_q;
  logic [3:0] cnt_q;
  logic [bits-1:0] sh_q;
  logic stop_q;
  wire last_slot = (cnt_q == 4'(bits));
  wire sda_bit = last_slot ? (rx_mode && ack_en) : (!rx_mode && !sh_q[bits-1]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q <= i2c_pkg::st_idle;
      qtr_q <= 2'h0;
      cnt_q <= 4'h0;
      sh_q <= '0;
      stop_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rx_byte <= '0;
      ack_seen <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      done <= 1'b0;
      case (ph_q)
        i2c_pkg::st_idle: begin
          if (start) begin
            // frame starts with scl held low by software after start condition
            ph_q <= i2c_pkg::st_low;
            sh_q <= tx_byte;
            cnt_q <= 4'h0;
            qtr_q <= 2'h0;
            busy <= 1'b1;
            scl_low <= 1'b1;
          end else if (stop_req) begin
            ph_q <= i2c_pkg::st_stop;
            qtr_q <= 2'h0;
            busy <= 1'b1;
            stop_q <= 1'b0;
            scl_low <= 1'b1;
            sda_low <= 1'b1;
          end
        end
        i2c_pkg::st_low: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h0) sda_low <= sda_bit;
          if (qtr_q == 2'h1) begin
            scl_low <= 1'b0;
            ph_q <= i2c_pkg::st_high;
            qtr_q <= 2'h0;
          end
        end
        i2c_pkg::st_high: if (tick) begin
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h0) begin
            if (last_slot) ack_seen <= !sda_in;
            else sh_q <= {sh_q[bits-2:0], sda_in};
          end
          if (qtr_q == 2'h1) begin
            scl_low <= 1'b1;
            qtr_q <= 2'h0;
            if (last_slot) begin
              ph_q <= i2c_pkg::st_idle;
              busy <= 1'b0;
              done <= 1'b1;
              rx_byte <= sh_q;
              sda_low <= 1'b0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              ph_q <= i2c_pkg::st_low;
            end
          end
        end
        i2c_pkg::st_stop: if (tick) begin
          // scl released, then sda released while scl high
          qtr_q <= qtr_q + 2'h1;
          if (qtr_q == 2'h1) scl_low <= 1'b0;
          if (qtr_q == 2'h3) begin
            sda_low <= 1'b0;
            ph_q <= i2c_pkg::st_idle;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: ph_q <= i2c_pkg::st_idle;
      endcase
    end
  end
endmodule : i2c_bit_engine

// >>> simplified_i2c_channel.sv
`timescale 1ns/1ps
module simplified_i2c_channel #(
  parameter int bits = i2c_pkg::frame_bits
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // i2c pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // interrupt
  output logic transfer_end_interrupt
);
  // registers
  logic [5:0] ctrl_q;
  logic [bits-1:0] tx_q;
  logic [15:0] div_q;
  logic ack_error_flag_q;
  logic end_q;
  logic [15:0] divcnt_q;
  logic tick_q;
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;
  logic go_q;
  logic stop_go_q;
  // write channel capture
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  // engine wires
  logic eng_busy;
  logic eng_done;
  logic [bits-1:0] eng_rx;
  logic eng_ack;
  logic eng_scl_low;
  logic eng_sda_low;

  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && (aw_q == i2c_pkg::ctrl_addr);
  wire wr_data = wr_fire && (aw_q == i2c_pkg::data_addr);
  wire wr_stat = wr_fire && (aw_q == i2c_pkg::status_addr);
  wire wr_div = wr_fire && (aw_q == i2c_pkg::div_addr);
  wire wr_ok = wr_ctrl || wr_data || wr_stat || wr_div;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire rx_mode = ctrl_q[i2c_pkg::ctrl_rx_bit];
  // ack driven only while software keeps the data output enabled
  wire ack_drive = ctrl_q[i2c_pkg::ctrl_ack_bit] && ctrl_q[i2c_pkg::ctrl_oe_bit];
  wire [31:0] status_word = {29'h0, ack_error_flag_q, end_q, eng_busy};
  wire [31:0] rd_word =
    (s_axi_araddr == i2c_pkg::ctrl_addr) ? {26'h0, ctrl_q} :
    (s_axi_araddr == i2c_pkg::data_addr) ? {{(32-bits){1'b0}}, eng_rx} :
    (s_axi_araddr == i2c_pkg::status_addr) ? status_word :
    (s_axi_araddr == i2c_pkg::div_addr) ? {16'h0, div_q} : 32'h0;
  wire rd_ok = (s_axi_araddr == i2c_pkg::ctrl_addr) || (s_axi_araddr == i2c_pkg::data_addr)
    || (s_axi_araddr == i2c_pkg::status_addr) || (s_axi_araddr == i2c_pkg::div_addr);
  // a transmit ack slot left high is an ack error
  wire ack_fail = eng_done && !rx_mode && !eng_ack && go_q;
  // software lines override the engine only when idle, forming start and stop
  // the stop command rewrites ctrl to the idle levels, so the engine must own the lines
  // from that write on, or both would be released at once ahead of the stop sequence
  wire eng_own = eng_busy || stop_go_q;
  wire scl_drive_low = eng_own ? eng_scl_low : !ctrl_q[i2c_pkg::ctrl_scl_bit];
  wire sda_drive_low = eng_own ? eng_sda_low
    : (ctrl_q[i2c_pkg::ctrl_oe_bit] && !ctrl_q[i2c_pkg::ctrl_sda_bit]);

  // write address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= i2c_pkg::resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? i2c_pkg::resp_okay : i2c_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= i2c_pkg::resp_okay;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? i2c_pkg::resp_okay : i2c_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // control, data and divider registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= i2c_pkg::ctrl_reset;
      tx_q <= '0;
      div_q <= i2c_pkg::div_reset;
      go_q <= 1'b0;
      stop_go_q <= 1'b0;
    end else begin
      go_q <= go_q && !eng_done;
      stop_go_q <= 1'b0;
      if (wr_ctrl && ws_q[0]) begin
        // stop bit is a self-clearing command
        ctrl_q <= {1'b0, w_q[4:0]};
        stop_go_q <= w_q[i2c_pkg::ctrl_stop_bit] && !eng_busy;
      end
      // writing data starts one frame: address, transmit or receive
      if (wr_data && ws_q[0] && !eng_busy) begin
        tx_q <= rx_mode ? {bits{1'b1}} : w_q[bits-1:0];
        go_q <= 1'b1;
      end
      if (wr_div && ws_q[0]) div_q[7:0] <= w_q[7:0];
      if (wr_div && ws_q[1]) div_q[15:8] <= w_q[15:8];
    end
  end

  // status flags, the hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_error_flag_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      if (ack_fail) ack_error_flag_q <= 1'b1;
      else if (wr_stat && ws_q[0] && w_q[i2c_pkg::stat_ackerr_bit]) ack_error_flag_q <= 1'b0;
      if (eng_done) end_q <= 1'b1;
      else if (wr_stat && ws_q[0] && w_q[i2c_pkg::stat_end_bit]) end_q <= 1'b0;
    end
  end

  // quarter-bit tick divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divcnt_q <= 16'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (divcnt_q >= div_q) begin
        divcnt_q <= 16'h0;
        tick_q <= 1'b1;
      end else begin
        divcnt_q <= divcnt_q + 16'h1;
      end
    end
  end

  // pins synchronised; scl only observed, stretching is not detected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_sync_q <= 2'b11;
      scl_sync_q <= 2'b11;
    end else begin
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_sync_q <= {scl_sync_q[0], scl_i};
    end
  end

  // open-drain pins: output is always low, enable pulls the wire
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      transfer_end_interrupt <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= scl_drive_low;
      sda_oe <= sda_drive_low;
      transfer_end_interrupt <= eng_done;
    end
  end

  logic launched_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) launched_q <= 1'b0;
    else launched_q <= go_q && !eng_done;
  end

  i2c_bit_engine #(.bits(bits)) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_q),
    .start(go_q && !launched_q),
    .stop_req(stop_go_q),
    .rx_mode(rx_mode),
    .ack_en(ack_drive),
    .tx_byte(tx_q),
    .sda_in(sda_sync_q[1]),
    .busy(eng_busy),
    .done(eng_done),
    .rx_byte(eng_rx),
    .ack_seen(eng_ack),
    .scl_low(eng_scl_low),
    .sda_low(eng_sda_low)
  );
endmodule : simplified_i2c_channel

// >>> i2c_channel_properties.sv
`timescale 1ns/1ps
module i2c_channel_properties #(
  parameter int bits = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and interrupt
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic transfer_end_interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // scl releases since the last end pulse; assumes no software scl release mid-transfer
  logic oe_q;
  logic [7:0] rel_q;
  logic [7:0] rel_d;
  assign rel_d = transfer_end_interrupt ? 8'h00 : rel_q + {7'h00, oe_q & ~scl_oe};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_q <= 1'b0;
      rel_q <= 8'h00;
    end else begin
      oe_q <= scl_oe;
      rel_q <= rel_d;
    end
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_lines_free: assert property (
    $rose(aresetn) |-> !scl_oe && !sda_oe && !transfer_end_interrupt)
    else $error("lines or interrupt active after reset");
  a_pins_open_drain: assert property (!scl_o && !sda_o)
    else $error("pin drives a high level");
  a_end_single_pulse: assert property (
    transfer_end_interrupt |=> !transfer_end_interrupt)
    else $error("end pulse longer than one cycle");
  a_frame_nine_clocks: assert property (
    transfer_end_interrupt |-> rel_q == bits + 1 || rel_q == 1)
    else $error("wrong clock count before end pulse");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
endmodule : i2c_channel_properties

bind simplified_i2c_channel i2c_channel_properties #(.bits(bits)) chk_u (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
  .transfer_end_interrupt(transfer_end_interrupt)
);

// >>> i2c_slave_model.sv
`timescale 1ns/1ps
module i2c_slave_model #(
  parameter logic [6:0] dev_addr = 7'h50
) (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  // observation
  output logic [7:0] last_byte,
  output logic master_ack
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rd_byte = 8'h3c;
  logic first = 1'b0;
  logic reading = 1'b0;
  logic sel = 1'b0;
  int cnt = -1;
  initial sda_pull = 1'b0;
  initial master_ack = 1'b1;
  initial last_byte = 8'h00;
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    first = 1'b1;
    sel = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) cnt = -1;
  always @(posedge scl) if (cnt >= 0) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else if (reading) master_ack = sda;
    cnt++;
  end
  always @(negedge scl) if (cnt >= 0) begin
    sda_pull = 1'b0;
    if (cnt == 8 && first) begin
      sel = sh[7:1] == dev_addr;
      reading = sh[0];
    end
    if (cnt == 8 && !first && !reading) last_byte = sh;
    if (cnt == 8 && (first || !reading)) sda_pull = sel;
    if (cnt == 9) begin
      // a master nack ends the read, so the line is free for stop
      if (reading && !first) begin
        rd_byte = ~rd_byte;
        sel = sel && !master_ack;
      end
      first = 1'b0;
      cnt = 0;
    end
    if (reading && sel && !first && cnt < 8) sda_pull = !rd_byte[7 - cnt];
  end
endmodule : i2c_slave_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, irq, pull, mack;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [7:0] got;
  // open-drain lines with pull-ups
  wire scl = ~(scl_oe & ~scl_o);
  wire sda = ~(sda_oe & ~sda_o) & ~pull;
  int num_errors = 0;
  int tests_run = 0;
  int irqs = 0;
  simplified_i2c_channel dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .transfer_end_interrupt(irq));
  i2c_slave_model slave_u (.scl(scl), .sda(sda), .sda_pull(pull), .last_byte(got),
    .master_ack(mack));
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) if (irq === 1'b1) irqs++;
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic fin(input logic [31:0] st, input int n);
    logic [31:0] v;
    // busy drops one cycle before the end flag sets, so wait for the end flag
    do rd(i2c_pkg::status_addr, v); while (v[i2c_pkg::stat_end_bit] !== 1'b1);
    chk("status", v, st);
    chk("irq count", 32'(irqs - n), 32'h1);
    wr(i2c_pkg::status_addr, 32'h6);
  endtask : fin
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [31:0] st);
    int n;
    n = irqs;
    wr(i2c_pkg::ctrl_addr, {24'h0, c});
    wr(i2c_pkg::data_addr, {24'h0, d});
    fin(st, n);
  endtask : xfer
  task automatic start_cond;
    wr(i2c_pkg::ctrl_addr, 32'h5);
    wr(i2c_pkg::ctrl_addr, 32'h4);
  endtask : start_cond
  task automatic stop_cond;
    int n;
    n = irqs;
    wr(i2c_pkg::ctrl_addr, 32'h27);
    fin(32'h2, n);
    chk("idle lines", {30'h0, scl, sda}, 32'h3);
  endtask : stop_cond
  task automatic t_regs;
    logic [31:0] v;
    rd(i2c_pkg::ctrl_addr, v);
    chk("ctrl", v, {26'h0, i2c_pkg::ctrl_reset});
    rd(i2c_pkg::status_addr, v);
    chk("status", v, 32'h0);
    rd(i2c_pkg::div_addr, v);
    chk("div", v, {16'h0, i2c_pkg::div_reset});
    rd(8'h10, v);
    chk("rresp", 32'(resp), 32'(i2c_pkg::resp_slverr));
    wr(8'h10, 32'h1);
    chk("bresp", 32'(resp), 32'(i2c_pkg::resp_slverr));
    // bit time of 8 cycles gives the 160 ns link clock
    wr(i2c_pkg::div_addr, 32'h1);
    rd(i2c_pkg::div_addr, v);
    chk("div", v, 32'h1);
  endtask : t_regs
  task automatic t_write;
    start_cond();
    xfer(8'h04, {7'h50, 1'b0}, 32'h2);
    xfer(8'h04, 8'ha5, 32'h2);
    chk("slave byte", {24'h0, got}, 32'ha5);
    stop_cond();
  endtask : t_write
  task automatic t_read;
    logic [31:0] v;
    start_cond();
    xfer(8'h04, {7'h50, 1'b1}, 32'h2);
    xfer(8'h1e, 8'hff, 32'h2);
    rd(i2c_pkg::data_addr, v);
    chk("rx byte", v, 32'h3c);
    chk("master ack", {31'h0, mack}, 32'h0);
    xfer(8'h0a, 8'hff, 32'h2);
    rd(i2c_pkg::data_addr, v);
    chk("rx byte", v, 32'hc3);
    chk("master ack", {31'h0, mack}, 32'h1);
    stop_cond();
  endtask : t_read
  task automatic t_nack;
    logic [31:0] v;
    start_cond();
    xfer(8'h04, {7'h51, 1'b0}, 32'h6);
    rd(i2c_pkg::status_addr, v);
    chk("status cleared", v, 32'h0);
    stop_cond();
  endtask : t_nack
  initial begin
    #500000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_write();
    t_read();
    t_nack();
    close_out();
  end
endmodule : tb_top
